// File: dv/bcs_link_asserts.sv
// Checker for the link between controller end and SRAM end.
// Assumes one clk domain and the K-as-clk/2 timing of the link.
module bcs_link_asserts
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic k,
  input wire logic kN,
  input wire logic loadStrobeN,
  input wire logic readSel,
  input wire logic [LANES-1:0] byteWriteMasks,
  input wire logic dqHostOe,
  input wire logic dqDevOe,
  input wire logic outputValidFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Command and burst shapes
  sequence rdCmd;
    k && !loadStrobeN && readSel;
  endsequence
  sequence wrCmd;
    k && !loadStrobeN && !readSel;
  endsequence
  sequence nopCmd;
    k && loadStrobeN;
  endsequence
  sequence rdBurst;
    (dqDevOe && outputValidFlag)[*2];
  endsequence
  sequence wrBurst;
    (dqHostOe && !dqDevOe)[*2];
  endsequence
  // ==========================================================
  // Properties
  read_burst_a: assert property (rdCmd |-> ##5 rdBurst)
    else $error("read did not drive two beats");
  oe_cause_a: assert property (dqDevOe |-> $past(k && !loadStrobeN && readSel, 5)
    || $past(k && !loadStrobeN && readSel, 6))
    else $error("device drove data without a read");
  write_beats_a: assert property (wrCmd |-> ##2 wrBurst)
    else $error("write beats not driven by controller");
  nop_release_a: assert property (nopCmd |-> ##5 !dqDevOe)
    else $error("drivers not off after deselect");
  valid_flag_a: assert property (outputValidFlag == dqDevOe)
    else $error("valid flag differs from read beats");
  no_clash_a: assert property (!(dqHostOe && dqDevOe))
    else $error("both ends drive data");
  mask_idle_a: assert property (!dqHostOe |-> byteWriteMasks == {LANES{1'b1}})
    else $error("masks enabled outside a write beat");
  clock_pair_a: assert property (k |=> !k && kN)
    else $error("timing pair not alternating");
endmodule : bcs_link_asserts

// File: dv/tb_top.sv
// Testbench: controller end and SRAM end joined by the link, random traffic.
// Assumes the queue stalls until lock, so the first writes fill it.
module tb_top
  import bcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, dllEnable, reqValid, reqIsRead, reqReady, rdValid;
  logic hostLocked, devLocked, dllActive, writeAborted;
  logic [ADDR_W-1:0] reqAddr;
  logic [WORD_W-1:0] reqWdata, rdData, d;
  logic [WORD_LANES-1:0] reqMaskN, m;
  logic [WORD_W-1:0] mem [0:15];
  logic [WORD_W-1:0] expQ [$];
  int n_mismatch, total_checks, nAbort, expAbort, cycles, i, n, a;
  bcs_link_if bcs_link_if_inst();
  bcs_host_end bcs_host_end_inst(.clk(clk), .reset_n(reset_n), .link(bcs_link_if_inst),
    .dllEnable(dllEnable), .dllLocked(hostLocked), .reqValid(reqValid), .reqReady(reqReady),
    .reqIsRead(reqIsRead), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqMaskN(reqMaskN),
    .rdValid(rdValid), .rdData(rdData));
  bcs_device_end bcs_device_end_inst(.clk(clk), .reset_n(reset_n), .link(bcs_link_if_inst),
    .dllActive(dllActive), .dllLocked(devLocked), .writeAborted(writeAborted));
  bcs_link_asserts bcs_link_asserts_inst(.clk(clk), .reset_n(reset_n), .k(bcs_link_if_inst.k),
    .kN(bcs_link_if_inst.kN), .loadStrobeN(bcs_link_if_inst.loadStrobeN),
    .readSel(bcs_link_if_inst.readSel), .byteWriteMasks(bcs_link_if_inst.byteWriteMasks),
    .dqHostOe(bcs_link_if_inst.dqHostOe), .dqDevOe(bcs_link_if_inst.dqDevOe),
    .outputValidFlag(bcs_link_if_inst.outputValidFlag));
  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================
  // Tasks
  task chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Model updated in push order; the port is coherent so order is enough
  task push(input logic rd, input int ad, input logic [WORD_W-1:0] dt, input logic [WORD_LANES-1:0] mk);
    reqValid <= 1'b1;
    reqIsRead <= rd;
    reqAddr <= ADDR_W'(ad);
    reqWdata <= dt;
    reqMaskN <= mk;
    @(posedge clk);
    while (reqReady !== 1'b1) @(posedge clk);
    if (rd)
      expQ.push_back(mem[ad]);
    else begin
      if (mk == 4'hf)
        expAbort++;
      for (int l = 0; l < WORD_LANES; l++)
        if (!mk[l])
          mem[ad][LANE_W*l+:LANE_W] = dt[LANE_W*l+:LANE_W];
    end
  endtask : push
  task idle;
    reqValid <= 1'b0;
    @(posedge clk);
  endtask : idle
  // ==========================================================
  // Read results and abort pulses
  always @(posedge clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0)
        chk(36'(rdValid), 36'h0);
      else
        chk(rdData, expQ.pop_front());
    end
    if (writeAborted === 1'b1)
      nAbort++;
  end
  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    dllEnable = 1'b1;
    reqValid = 1'b0;
    reqIsRead = 1'b0;
    reqAddr = 8'h00;
    reqWdata = 36'h0;
    reqMaskN = 4'hf;
    cycles = 0;
    void'($urandom(32'h24b86762));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Fill queue before lock; full words seed every address
    for (i = 0; i < FIFO_DEPTH; i++)
      push(1'b0, i, WORD_W'({$urandom(), $urandom()}), 4'h0);
    idle();
    @(posedge clk);
    chk(36'(reqReady), 36'h0);
    chk(36'(hostLocked), 36'h0);
    n = 0;
    while (hostLocked !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(36'(n >= 4000), 36'h1);
    chk(36'(devLocked), 36'h1);
    chk(36'(dllActive), 36'h1);
    // Mixed traffic; masked lanes, aborts, write then read of one word
    for (i = 0; i < 80; i++) begin
      a = $urandom % 16;
      d = WORD_W'({$urandom(), $urandom()});
      m = (i % 7 == 3) ? 4'hf : WORD_LANES'($urandom);
      if ($urandom % 3 == 0)
        push(1'b1, a, d, m);
      else begin
        push(1'b0, a, d, m);
        if ($urandom % 2)
          push(1'b1, a, d, m);
      end
      if ($urandom % 4 == 0)
        idle();
    end
    for (i = 0; i < 16; i++)
      push(1'b1, i, 36'h0, 4'hf);
    idle();
    n = 0;
    while (expQ.size() > 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk(36'(expQ.size()), 36'h0);
    chk(36'(nAbort), 36'(expAbort));
    // DLL off input follows the enable
    dllEnable <= 1'b0;
    repeat (6) @(posedge clk);
    chk(36'(dllActive), 36'h0);
    conclude();
  end
endmodule : tb_top

// File: src/bcs_device_end.sv
// SRAM end of the burst-of-two common-I/O port: command pipeline, late write,
// pipelined read and the storage array.
// Assumes the controller shares clk and toggles K each clk, so a K period is two clk.
//
// Summary of operation
// - Command pins sampled only at K rise
// - Load low, select high means pipelined read
// - Write data first beat at next K rise
// - Second write beat at following inverted-K rise
// - Every read or write moves exactly two data beats
// - New command accepted every K cycle
// - Deselect pipelined; pending read beats complete first
// - Load high ignores select and address
// - Byte masks sampled with each data beat
// - Masked byte keeps its stored contents
// - Nine-bit lanes, each with own mask
// - Beat one low half, beat two high
// - DLL off while off input low
// - Drivers off 2.5 K cycles after deselect/write
// - Controller waits 2048 K cycles for lock
// - Lane masked in both beats stores nothing
module bcs_device_end
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  bcs_link_if.device link,
  output logic dllActive,
  output logic dllLocked,
  output logic writeAborted
);
  localparam int DEPTH = 1 << ADDR_W;
  typedef struct packed {
    logic [PIPE_LEN-1:0] rdSh;
    logic [WR_PIPE_LEN-1:0] wrSh;
    logic [PIPE_LEN-1:0][ADDR_W-1:0] addrSh;
    logic [DQ_W-1:0] wrLo;
    logic [LANES-1:0] wrLoMaskN;
    logic [DQ_W-1:0] rdHi;
    logic [DQ_W-1:0] dqOut;
    logic dqOe;
    logic qValid;
    logic dllOn;
    logic [LOCK_CNT_W-1:0] lockCnt;
    logic locked;
    logic aborted;
  } bcs_dev_s;
  bcs_dev_s st_ff;
  bcs_dev_s nxt_st;
  // One array per lane so each lane's write process owns its own storage
  logic [LANE_W-1:0] mem [WORD_LANES][DEPTH];
  logic [WORD_W-1:0] rdWord;
  logic [WORD_W-1:0] wrWord;
  logic [WORD_LANES-1:0] wrLaneMaskN;
  logic [WORD_LANES-1:0] laneWe;
  logic wrCommit;
  logic [ADDR_W-1:0] wrAddr;
  logic cmdLoad;
  // ==========================================================
  // Command capture
  // Only the K-high cycle counts; inverted-K edges never load a command
  assign cmdLoad = link.k && !link.loadStrobeN;
  // ==========================================================
  // Late-write assembly
  // The word is built from the held first beat and the live second beat
  assign wrCommit = st_ff.wrSh[WR_BEAT2_STG];
  assign wrAddr = st_ff.addrSh[WR_BEAT2_STG];
  assign wrWord = {link.dq, st_ff.wrLo};
  assign wrLaneMaskN = {link.byteWriteMasks, st_ff.wrLoMaskN};
  // ==========================================================
  // Per-lane storage, write enables and array read
  genvar gl;
  generate
    for (gl = 0; gl < WORD_LANES; gl++) begin : gLane
      assign laneWe[gl] = wrCommit && !wrLaneMaskN[gl];
      always_ff @(posedge clk) begin
        if (laneWe[gl]) begin
          mem[gl][wrAddr] <= wrWord[gl*LANE_W +: LANE_W];
        end
      end
      // Taken one cycle before the first read beat; any write loaded earlier
      // has already committed by then, so no bypass path is needed
      assign rdWord[gl*LANE_W +: LANE_W] = mem[gl][st_ff.addrSh[RD_BEAT1_STG]];
    end
  endgenerate
  // ==========================================================
  // Pipeline
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdSh = {st_ff.rdSh[PIPE_LEN-2:0], cmdLoad && link.readSel};
    nxt_st.wrSh = {st_ff.wrSh[WR_PIPE_LEN-2:0], cmdLoad && !link.readSel};
    nxt_st.addrSh = {st_ff.addrSh[PIPE_LEN-2:0], link.addressInputs};
    // First write beat with its masks
    if (st_ff.wrSh[WR_BEAT1_STG]) begin
      nxt_st.wrLo = link.dq;
      nxt_st.wrLoMaskN = link.byteWriteMasks;
    end
    // Abort flag when no lane stored in either beat
    nxt_st.aborted = wrCommit && (laneWe == '0);
    // Read beats leave the mux low half first
    nxt_st.dqOe = 1'b0;
    nxt_st.qValid = 1'b0;
    if (st_ff.rdSh[RD_BEAT1_STG]) begin
      nxt_st.dqOe = 1'b1;
      nxt_st.qValid = 1'b1;
      nxt_st.dqOut = rdWord[DQ_W-1:0];
      nxt_st.rdHi = rdWord[WORD_W-1:DQ_W];
    end else if (st_ff.rdSh[RD_BEAT2_STG]) begin
      nxt_st.dqOe = 1'b1;
      nxt_st.qValid = 1'b1;
      nxt_st.dqOut = st_ff.rdHi;
    end
    // Deselect and write slots leave the drivers off for a full K cycle
    // at the same latency a read would have used
    if (!st_ff.rdSh[RD_BEAT1_STG] && !st_ff.rdSh[RD_BEAT2_STG]) begin
      nxt_st.dqOe = 1'b0;
    end
    // DLL model: runs only while the off input is high
    nxt_st.dllOn = link.dllOffN;
    if (!link.dllOffN) begin
      nxt_st.lockCnt = '0;
      nxt_st.locked = 1'b0;
    end else if (!st_ff.locked) begin
      nxt_st.lockCnt = st_ff.lockCnt + LOCK_CNT_W'(1);
      nxt_st.locked = (st_ff.lockCnt == LOCK_CNT_W'(DLL_LOCK_CLKS - 1));
    end
  end
  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{wrLoMaskN: '1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ==========================================================
  // Outputs
  assign link.dqFromDev = st_ff.dqOut;
  assign link.dqDevOe = st_ff.dqOe;
  assign link.outputValidFlag = st_ff.qValid;
  assign dllActive = st_ff.dllOn;
  assign dllLocked = st_ff.locked;
  assign writeAborted = st_ff.aborted;
endmodule : bcs_device_end

// File: src/bcs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; full and empty are registered.
module bcs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic full;
    logic empty;
  } bcs_fifo_s;
  bcs_fifo_s st_ff;
  bcs_fifo_s nxt_st;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;
  logic [AW:0] fill;
  // ==========================================================
  // Pointer logic
  always_comb begin
    nxt_st = st_ff;
    push = inValid && !st_ff.full;
    pop = outReady && !st_ff.empty;
    if (push) begin
      nxt_st.wrPtr = st_ff.wrPtr + (AW+1)'(1);
    end
    if (pop) begin
      nxt_st.rdPtr = st_ff.rdPtr + (AW+1)'(1);
    end
    fill = nxt_st.wrPtr - nxt_st.rdPtr;
    nxt_st.full = (fill == (AW+1)'(DEPTH));
    nxt_st.empty = (fill == '0);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{wrPtr: '0, rdPtr: '0, full: 1'b0, empty: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Storage has no reset; only slots behind the pointers are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_ff.wrPtr[AW-1:0]] <= inData;
    end
  end
  assign inReady = !st_ff.full;
  assign outValid = !st_ff.empty;
  assign outData = mem[st_ff.rdPtr[AW-1:0]];
endmodule : bcs_fifo

// File: src/bcs_host_end.sv
// Controller end: queues user requests and drives the SRAM link.
// Assumes the SRAM end shares clk; K and its inverse are made here by toggling.
module bcs_host_end
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  bcs_link_if.host link,
  input wire logic dllEnable,
  output logic dllLocked,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqIsRead,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [WORD_W-1:0] reqWdata,
  input wire logic [WORD_LANES-1:0] reqMaskN,
  output logic rdValid,
  output logic [WORD_W-1:0] rdData
);
  typedef enum logic [1:0] {
    HS_DLL_OFF = 2'b00,
    HS_LOCKING = 2'b01,
    HS_READY = 2'b11
  } bcs_host_e;
  typedef struct packed {
    bcs_host_e state;
    logic [LOCK_CNT_W-1:0] lockCnt;
    logic locked;
    logic k;
    logic loadStrobeN;
    logic readSel;
    logic [ADDR_W-1:0] addr;
    logic lastRead;
    logic lastRead2;
    logic [WORD_W-1:0] cmdWord;
    logic [WORD_LANES-1:0] cmdMaskN;
    logic [WORD_W-1:0] beatWord;
    logic [WORD_LANES-1:0] beatMaskN;
    logic [WR_PIPE_LEN-1:0] wrSh;
    // One stage longer than the device; the second read beat lands a cycle later
    logic [PIPE_LEN:0] rdSh;
    logic [DQ_W-1:0] dqOut;
    logic dqOe;
    logic [LANES-1:0] masksN;
    logic [DQ_W-1:0] rdLo;
    logic rdValid;
    logic [WORD_W-1:0] rdData;
  } bcs_host_s;
  bcs_host_s st_ff;
  bcs_host_s nxt_st;
  bcs_req_s head;
  logic headValid;
  logic headPop;
  logic cmdEdge;
  // ==========================================================
  // Request queue
  bcs_fifo #(.W(REQ_W), .DEPTH(FIFO_DEPTH)) reqFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData({reqIsRead, reqAddr, reqWdata, reqMaskN}),
    .outValid(headValid),
    .outReady(headPop),
    .outData(head)
  );
  // ==========================================================
  // Link sequencing
  always_comb begin
    nxt_st = st_ff;
    headPop = 1'b0;
    nxt_st.k = !st_ff.k;
    cmdEdge = st_ff.k && !st_ff.loadStrobeN;
    nxt_st.rdValid = 1'b0;
    nxt_st.wrSh = {st_ff.wrSh[WR_PIPE_LEN-2:0], cmdEdge && !st_ff.readSel};
    nxt_st.rdSh = {st_ff.rdSh[PIPE_LEN-1:0], cmdEdge && st_ff.readSel};
    unique case (st_ff.state)
      HS_DLL_OFF: begin
        if (dllEnable) begin
          nxt_st.state = HS_LOCKING;
          nxt_st.lockCnt = '0;
        end
      end
      HS_LOCKING: begin
        nxt_st.lockCnt = st_ff.lockCnt + LOCK_CNT_W'(1);
        if (st_ff.lockCnt == LOCK_CNT_W'(DLL_LOCK_CLKS - 1)) begin
          nxt_st.state = HS_READY;
        end
      end
      HS_READY: begin
      end
      default: begin
        nxt_st.state = HS_DLL_OFF;
      end
    endcase
    if (!dllEnable) begin
      nxt_st.state = HS_DLL_OFF;
    end
    nxt_st.locked = (nxt_st.state == HS_READY);
    // Commands change as K rises so they are stable across the K-high cycle
    if (!st_ff.k) begin
      nxt_st.loadStrobeN = 1'b1;
      // Read beats end 3.5 K after the read; a write needs two gap slots after it
      if (st_ff.locked && headValid && !(!head.isRead && (st_ff.lastRead || st_ff.lastRead2))) begin
        headPop = 1'b1;
        nxt_st.loadStrobeN = 1'b0;
        nxt_st.readSel = head.isRead;
        nxt_st.addr = head.addr;
        nxt_st.cmdWord = head.wdata;
        nxt_st.cmdMaskN = head.maskN;
      end
      nxt_st.lastRead = headPop && head.isRead;
      nxt_st.lastRead2 = st_ff.lastRead;
    end
    if (cmdEdge && !st_ff.readSel) begin
      nxt_st.beatWord = st_ff.cmdWord;
      nxt_st.beatMaskN = st_ff.cmdMaskN;
    end
    // Write beats with masks aligned to the data
    nxt_st.dqOe = 1'b0;
    nxt_st.masksN = '1;
    if (st_ff.wrSh[0]) begin
      nxt_st.dqOe = 1'b1;
      nxt_st.dqOut = st_ff.beatWord[DQ_W-1:0];
      nxt_st.masksN = st_ff.beatMaskN[LANES-1:0];
    end else if (st_ff.wrSh[WR_BEAT1_STG]) begin
      nxt_st.dqOe = 1'b1;
      nxt_st.dqOut = st_ff.beatWord[WORD_W-1:DQ_W];
      nxt_st.masksN = st_ff.beatMaskN[WORD_LANES-1:LANES];
    end
    // Read beats arrive 2.5 K cycles after the command
    if (st_ff.rdSh[RD_BEAT2_STG]) begin
      nxt_st.rdLo = link.dq;
    end
    if (st_ff.rdSh[RD_BEAT2_STG+1]) begin
      nxt_st.rdValid = 1'b1;
      nxt_st.rdData = {link.dq, st_ff.rdLo};
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{state: HS_DLL_OFF, loadStrobeN: 1'b1, masksN: '1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ==========================================================
  // Pin drive
  assign link.k = st_ff.k;
  assign link.kN = !st_ff.k;
  assign link.loadStrobeN = st_ff.loadStrobeN;
  assign link.readSel = st_ff.readSel;
  assign link.addressInputs = st_ff.addr;
  assign link.byteWriteMasks = st_ff.masksN;
  assign link.dqFromHost = st_ff.dqOut;
  assign link.dqHostOe = st_ff.dqOe;
  assign link.dllOffN = (st_ff.state != HS_DLL_OFF);
  assign dllLocked = st_ff.locked;
  assign rdValid = st_ff.rdValid;
  assign rdData = st_ff.rdData;
endmodule : bcs_host_end

// File: src/bcs_link_if.sv
// Pin-level link between the SRAM port and its controller.
// Assumes both ends run on the same clk; the shared data wire is resolved here.
interface bcs_link_if;
  logic k;
  logic kN;
  logic loadStrobeN;
  logic readSel;
  logic dllOffN;
  logic [bcs_pkg::ADDR_W-1:0] addressInputs;
  logic [bcs_pkg::LANES-1:0] byteWriteMasks;
  logic [bcs_pkg::DQ_W-1:0] dqFromHost;
  logic [bcs_pkg::DQ_W-1:0] dqFromDev;
  logic [bcs_pkg::DQ_W-1:0] dq;
  logic dqHostOe;
  logic dqDevOe;
  logic outputValidFlag;
  // ==========================================================
  // Wire level; device wins if both drive, which the controller avoids
  assign dq = dqDevOe ? dqFromDev : dqFromHost;
  modport device (input k, kN, loadStrobeN, readSel, dllOffN, addressInputs, byteWriteMasks, dq,
                  output dqFromDev, dqDevOe, outputValidFlag);
  modport host (output k, kN, loadStrobeN, readSel, dllOffN, addressInputs, byteWriteMasks, dqFromHost,
                dqHostOe, input dq, outputValidFlag);
endinterface : bcs_link_if

// File: src/bcs_pkg.sv
// Shared constants and types for the burst-of-two common-I/O SRAM port.
// Assumes one 50 MHz clock; the link K period is two clk cycles.
package bcs_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DQ_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int WORD_W = 2 * DQ_W;
  localparam int WORD_LANES = 2 * LANES;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int K_CLKS = 2;
  localparam int DLL_LOCK_K = 2048;
  localparam int DLL_LOCK_CLKS = DLL_LOCK_K * K_CLKS;
  localparam int LOCK_CNT_W = 13;
  // Stage n is live n+1 clk cycles after the command cycle
  localparam int WR_BEAT1_STG = 1;
  localparam int WR_BEAT2_STG = 2;
  localparam int RD_BEAT1_STG = 3;
  localparam int RD_BEAT2_STG = 4;
  localparam int PIPE_LEN = 5;
  localparam int WR_PIPE_LEN = 3;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // Request word queued in the controller
  typedef struct packed {
    logic isRead;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic [WORD_LANES-1:0] maskN;
  } bcs_req_s;
  localparam int REQ_W = $bits(bcs_req_s);
endpackage : bcs_pkg
